// >>> bench/ccdo_exec_assertions.sv
// checker for the execute block's bus and busy ports
`timescale 1ns/100ps
module ccdo_exec_assertions
  import ccdo_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic iw;
  assign iw = psel && penable && pready && pwrite && paddr == 12'h000 && !busy;
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("pready outside access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr alone");
  property p_rdz; !(pready && !pwrite) |-> prdata == 32'h0000_0000; endproperty
  a_rdz: assert property (p_rdz) else $error("prdata not zero");
  property p_unm; pready && paddr == 12'h01C |-> pslverr; endproperty
  a_unm: assert property (p_unm) else $error("unmapped accepted");
  property p_call; iw && pwdata[13:11] == 3'b100 |=> busy [*2] ##1 !busy; endproperty
  a_call: assert property (p_call) else $error("call length");
  property p_one; iw && pwdata[13:12] == 2'b00 && pwdata[11:8] != 4'hB |=> busy ##1 !busy;
  endproperty
  a_one: assert property (p_one) else $error("single op length");
  property p_skip; iw && pwdata[13:8] == 6'h0B |=> busy ##[1:2] !busy; endproperty
  a_skip: assert property (p_skip) else $error("skip length");
  c_call: cover property (iw && pwdata[13:11] == 3'b100);
  c_err: cover property (pslverr);
  c_rd: cover property (pready && !pwrite && prdata != 32'h0000_0000);
endmodule
bind ccdo_exec ccdo_exec_assertions ccdo_exec_assertions_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .busy);

// >>> bench/tb_call_clear_complement_decrement_ops.sv
// testbench for the execute block
`timescale 1ns/100ps
module tb_call_clear_complement_decrement_ops;
  import ccdo_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int          fail_count, checked;
  logic [13:0] ops [8] = '{14'h0185, 14'h0100, 14'h0905, 14'h0985, 14'h0305, 14'h0385,
                           14'h0B85, 14'h0B05};
  logic [7:0]  fin [8] = '{8'h55, 8'h55, 8'hFF, 8'h0F, 8'h01, 8'h00, 8'h01, 8'h03};
  logic [7:0]  fex [8] = '{8'h00, 8'h55, 8'hFF, 8'hF0, 8'h01, 8'hFF, 8'h00, 8'h03};
  logic [7:0]  aex [8] = '{8'h5A, 8'h00, 8'h00, 8'h5A, 8'h00, 8'h5A, 8'h5A, 8'h02};
  logic        zex [8] = '{1, 1, 1, 0, 1, 0, 0, 0};
  logic [1:0]  pdx [8] = '{1, 1, 1, 1, 1, 1, 2, 1};
  ccdo_exec ccdo_exec_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy));
  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      chk("pready", {31'h0, pready}, 32'h1);
      wrap_up;
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x, input string n);
    xfer(0, a, 32'h0);
    chk(n, q, x);
  endtask
  // issue an opcode and poll the busy status bit
  task ex(input logic [13:0] op);
    int n;
    xfer(1, 12'h000, {18'h0, op});
    n = 0;
    do begin
      xfer(0, 12'h010, 32'h0);
      n++;
    end while (q[8] !== 1'b0 && n < 8);
    if (n >= 8) chk("busy", q, 32'h6);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    fail_count = 0;
    checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rd(12'h010, 32'h6, "status");
    rd(12'h01C, 32'h0, "unmapped");
    chk("slverr", {31'h0, e}, 32'h1);
    xfer(1, 12'h008, 32'h18);
    xfer(1, 12'h004, 32'h0123);
    ex(14'h27FF);
    rd(12'h004, 32'h1FFF, "pc");
    rd(12'h014, 32'h0124, "stack");
    rd(12'h010, 32'h6, "status");
    repeat (600) @(posedge pclk);
    xfer(1, 12'h010, 32'h1);
    ex(14'h0064);
    rd(12'h018, 32'h0, "wdt");
    repeat (200) @(posedge pclk);
    rd(12'h018, 32'h0, "wdt");
    rd(12'h010, 32'h7, "status");
    for (int i = 0; i < 8; i++) begin
      xfer(1, 12'h214, {24'h0, fin[i]});
      xfer(1, 12'h00C, 32'h5A);
      xfer(1, 12'h010, 32'h0);
      xfer(1, 12'h004, 32'h100);
      ex(ops[i]);
      rd(12'h214, {24'h0, fex[i]}, "file");
      rd(12'h00C, {24'h0, aex[i]}, "acc");
      rd(12'h010, {31'h3, zex[i]}, "status");
      rd(12'h004, 32'h100 + pdx[i], "pc");
    end
    wrap_up;
  end
endmodule

// >>> hdl/ccdo_exec.sv
// execute unit for call, watchdog kick, clear, complement and decrement instructions
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/100ps
module ccdo_exec
  import ccdo_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             busy
);

  ccdo_state_t   s_r;
  ccdo_state_t   s_nxt;
  ccdo_apb_req_t req;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  function automatic ccdo_sel_t reg_sel(input logic [11:0] a);
    if (a == `CCDO_OFS_INSTR) begin
      reg_sel = CCDO_SEL_INSTR;
    end else if (a == `CCDO_OFS_PC) begin
      reg_sel = CCDO_SEL_PC;
    end else if (a == `CCDO_OFS_LATCH) begin
      reg_sel = CCDO_SEL_LATCH;
    end else if (a == `CCDO_OFS_ACC) begin
      reg_sel = CCDO_SEL_ACC;
    end else if (a == `CCDO_OFS_STATUS) begin
      reg_sel = CCDO_SEL_STATUS;
    end else if (a == `CCDO_OFS_STACK) begin
      reg_sel = CCDO_SEL_STACK;
    end else if (a == `CCDO_OFS_WDT) begin
      reg_sel = CCDO_SEL_WDT;
    end else if (a >= `CCDO_OFS_FILE && a <= `CCDO_FILE_END && a[1:0] == 2'b00) begin
      reg_sel = CCDO_SEL_FILE;
    end else begin
      reg_sel = CCDO_SEL_NONE;
    end
  endfunction

  always_comb begin
    logic [6:0]            fa;
    logic [7:0]            fval;
    logic [7:0]            res;
    logic                  dst_reg;
    logic [6:0]            wa;
    ccdo_sel_t             sel;
    logic                  wr_now;
    logic [`CCDO_PC_W-1:0] pc_inc;
    fa      = s_r.op[6:0];
    fval    = s_r.file[fa];
    res     = `CCDO_DATA_ZERO;
    dst_reg = s_r.op[7];
    wa      = req.paddr[8:2];
    sel     = reg_sel(req.paddr);
    pc_inc  = s_r.pc + `CCDO_PC_W'(1);
    s_nxt   = s_r;

    // free-running watchdog; a full wrap drops the expiry flag (active low)
    s_nxt.pre = s_r.pre + `CCDO_PRE_W'(1);
    if (&s_r.pre) begin
      s_nxt.wdt = s_r.wdt + 8'h01;
      if (&s_r.wdt) begin
        s_nxt.expiry_flag = 1'b0;
      end
    end

    // bus writes land first so instruction effects in the same cycle win
    wr_now = req.psel && req.penable && req.pwrite && s_r.pready;
    if (wr_now) begin
      if (sel == CCDO_SEL_PC) begin
        s_nxt.pc = req.pwdata[`CCDO_PC_W-1:0];
      end else if (sel == CCDO_SEL_LATCH) begin
        s_nxt.latch = req.pwdata[4:0];
      end else if (sel == CCDO_SEL_ACC) begin
        s_nxt.acc = req.pwdata[7:0];
      end else if (sel == CCDO_SEL_STATUS) begin
        s_nxt.null_flag = req.pwdata[`CCDO_ST_NULL];
      end else if (sel == CCDO_SEL_FILE) begin
        s_nxt.file[wa] = req.pwdata[7:0];
      end else if (sel == CCDO_SEL_INSTR && s_r.phase == CCDO_IDLE) begin
        s_nxt.op    = req.pwdata[13:0];
        s_nxt.phase = CCDO_EXEC;
      end
    end

    case (s_r.phase)
      CCDO_IDLE: begin
      end
      CCDO_EXEC: begin
        s_nxt.phase = CCDO_IDLE;
        s_nxt.pc    = pc_inc;
        casez (s_r.op)
          `CCDO_OP_CALL: begin
            s_nxt.stack_top = pc_inc;
            s_nxt.pc        = {s_r.latch[4:3], s_r.op[10:0]};
            s_nxt.phase     = CCDO_SECOND;
          end
          `CCDO_OP_KICK: begin
            s_nxt.wdt         = `CCDO_WDT_ZERO;
            s_nxt.pre         = '0;
            s_nxt.expiry_flag = 1'b1;
            s_nxt.sleep_flag  = 1'b1;
          end
          `CCDO_OP_REGZERO: begin
            s_nxt.file[fa]  = `CCDO_DATA_ZERO;
            s_nxt.null_flag = 1'b1;
          end
          `CCDO_OP_ACCZERO: begin
            s_nxt.acc       = `CCDO_DATA_ZERO;
            s_nxt.null_flag = 1'b1;
          end
          `CCDO_OP_INVERT: begin
            res = ~fval;
            if (dst_reg) begin
              s_nxt.file[fa] = res;
            end else begin
              s_nxt.acc = res;
            end
            s_nxt.null_flag = (res == `CCDO_DATA_ZERO);
          end
          `CCDO_OP_DOWN: begin
            res = fval - 8'h01;
            if (dst_reg) begin
              s_nxt.file[fa] = res;
            end else begin
              s_nxt.acc = res;
            end
            s_nxt.null_flag = (res == `CCDO_DATA_ZERO);
          end
          `CCDO_OP_DOWNSKIP: begin
            res = fval - 8'h01;
            if (dst_reg) begin
              s_nxt.file[fa] = res;
            end else begin
              s_nxt.acc = res;
            end
            if (res == `CCDO_DATA_ZERO) begin
              // next word is stepped over and an idle cycle stands in its place
              s_nxt.pc    = s_r.pc + `CCDO_PC_W'(2);
              s_nxt.phase = CCDO_SECOND;
            end
          end
          default: begin
          end
        endcase
      end
      CCDO_SECOND: begin
        s_nxt.phase = CCDO_IDLE;
      end
      default: begin
        s_nxt.phase = CCDO_IDLE;
      end
    endcase

    // zero-wait answer: data and ready captured in the setup cycle
    s_nxt.pready  = req.psel && !req.penable;
    s_nxt.pslverr = req.psel && !req.penable && (sel == CCDO_SEL_NONE);
    s_nxt.prdata  = 32'h0000_0000;
    if (req.psel && !req.penable && !req.pwrite) begin
      if (sel == CCDO_SEL_INSTR) begin
        s_nxt.prdata[13:0] = s_r.op;
      end else if (sel == CCDO_SEL_PC) begin
        s_nxt.prdata[`CCDO_PC_W-1:0] = s_r.pc;
      end else if (sel == CCDO_SEL_LATCH) begin
        s_nxt.prdata[4:0] = s_r.latch;
      end else if (sel == CCDO_SEL_ACC) begin
        s_nxt.prdata[7:0] = s_r.acc;
      end else if (sel == CCDO_SEL_STATUS) begin
        s_nxt.prdata[`CCDO_ST_NULL]   = s_r.null_flag;
        s_nxt.prdata[`CCDO_ST_SLEEP]  = s_r.sleep_flag;
        s_nxt.prdata[`CCDO_ST_EXPIRY] = s_r.expiry_flag;
        s_nxt.prdata[`CCDO_ST_BUSY]   = (s_r.phase != CCDO_IDLE);
      end else if (sel == CCDO_SEL_STACK) begin
        s_nxt.prdata[`CCDO_PC_W-1:0] = s_r.stack_top;
      end else if (sel == CCDO_SEL_WDT) begin
        s_nxt.prdata[7:0] = s_r.wdt;
      end else if (sel == CCDO_SEL_FILE) begin
        s_nxt.prdata[7:0] = s_r.file[wa];
      end
    end
    s_nxt.busy = (s_nxt.phase != CCDO_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r             <= '0;
      s_r.pc          <= `CCDO_RST_PC;
      s_r.sleep_flag  <= `CCDO_RST_FLAG;
      s_r.expiry_flag <= `CCDO_RST_FLAG;
      s_r.phase       <= CCDO_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata  = s_r.prdata;
  assign pready  = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign busy    = s_r.busy;

endmodule

// >>> hdl/ccdo_pkg.sv
// types shared by the execute block
package ccdo_pkg;
  `include "ccdo_regs.svh"

  typedef enum logic [1:0] {
    CCDO_IDLE,
    CCDO_EXEC,
    CCDO_SECOND
  } ccdo_phase_t;

  typedef enum logic [3:0] {
    CCDO_SEL_INSTR,
    CCDO_SEL_PC,
    CCDO_SEL_LATCH,
    CCDO_SEL_ACC,
    CCDO_SEL_STATUS,
    CCDO_SEL_STACK,
    CCDO_SEL_WDT,
    CCDO_SEL_FILE,
    CCDO_SEL_NONE
  } ccdo_sel_t;

  typedef struct packed {
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [11:0]             paddr;
    logic [31:0]             pwdata;
  } ccdo_apb_req_t;

  typedef struct packed {
    logic [`CCDO_PC_W-1:0]   pc;
    logic [4:0]              latch;
    logic [7:0]              acc;
    logic                    null_flag;
    logic                    sleep_flag;
    logic                    expiry_flag;
    logic [`CCDO_PC_W-1:0]   stack_top;
    logic [7:0]              wdt;
    logic [`CCDO_PRE_W-1:0]  pre;
    logic [13:0]             op;
    ccdo_phase_t             phase;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    busy;
    logic [127:0][7:0]       file;
  } ccdo_state_t;
endpackage

// >>> hdl/ccdo_regs.svh
// register offsets, field positions, reset values and opcode patterns for the execute block
// What this block does
// - call pushes pc plus one onto stack_top
// - call loads 11-bit target, takes two cycles
// - call takes pc 12:11 from latch 4:3
// - watchdog kick zeroes count and prescaler
// - watchdog kick sets expiry and sleep flags
// - register zero writes 00h, sets null flag
// - accumulator zero writes 00h, sets null flag
// - invert routes complement by destination bit
// - decrement routes result by destination bit
// - decrement-skip routes result, flags untouched
// - zero decrement-skip result idles second cycle
`ifndef CCDO_REGS_SVH
`define CCDO_REGS_SVH

`define CCDO_OFS_INSTR    12'h000
`define CCDO_OFS_PC       12'h004
`define CCDO_OFS_LATCH    12'h008
`define CCDO_OFS_ACC      12'h00C
`define CCDO_OFS_STATUS   12'h010
`define CCDO_OFS_STACK    12'h014
`define CCDO_OFS_WDT      12'h018
`define CCDO_OFS_FILE     12'h200
`define CCDO_FILE_END     12'h3FC

`define CCDO_ST_NULL      0
`define CCDO_ST_SLEEP     1
`define CCDO_ST_EXPIRY    2
`define CCDO_ST_BUSY      8

`define CCDO_PC_W         13
`define CCDO_PRE_W        8
`define CCDO_RST_PC       13'h0000
`define CCDO_RST_FLAG     1'b1
`define CCDO_WDT_ZERO     8'h00
`define CCDO_DATA_ZERO    8'h00

`define CCDO_OP_CALL      14'b10_0???_????_????
`define CCDO_OP_KICK      14'b00_0000_0110_0100
`define CCDO_OP_REGZERO   14'b00_0001_1???_????
`define CCDO_OP_ACCZERO   14'b00_0001_0???_????
`define CCDO_OP_INVERT    14'b00_1001_????_????
`define CCDO_OP_DOWN      14'b00_0011_????_????
`define CCDO_OP_DOWNSKIP  14'b00_1011_????_????

`endif
